// *** logic/ucfg_params.svh ***
`ifndef UCFG_PARAMS_SVH
`define UCFG_PARAMS_SVH
// ----------------------------------------
// configuration indices
// ----------------------------------------
`define UCFG_IDX_IRQ_ROUTE 8'h1D
`define UCFG_IDX_CLOCK 8'h1E
`define UCFG_IDX_RSVD_A 8'h1F
`define UCFG_IDX_RSVD_B 8'h20
`define UCFG_IDX_RSVD_C 8'h21
`define UCFG_IDX_RSVD_D 8'h22
`define UCFG_IDX_RSVD_E 8'h23
`define UCFG_IDX_BASE1 8'h24
`define UCFG_IDX_BASE2 8'h25
`define UCFG_IDX_RSVD_F 8'h26
`define UCFG_IDX_RSVD_G 8'h27
// ----------------------------------------
// reset values
// ----------------------------------------
`define UCFG_RST_IRQ_ROUTE 8'h00
`define UCFG_RST_CLOCK 8'h00
`define UCFG_RST_BASE 8'h00
`define UCFG_RST_RSVD_A 8'h00
`define UCFG_RST_RSVD_B 8'h3C
`define UCFG_RST_RSVD_F 8'hFF
// ----------------------------------------
// field positions
// ----------------------------------------
`define UCFG_ROUTE3_HI 7
`define UCFG_ROUTE3_LO 4
`define UCFG_ROUTE4_HI 3
`define UCFG_ROUTE4_LO 0
`define UCFG_CLK_ABSENT_BIT 0
`define UCFG_CLK_RSVD_BIT 1
// ----------------------------------------
// host command register map
// ----------------------------------------
`define UCFG_HREG_CMD 4'h0
`define UCFG_HREG_DATA 4'h1
`define UCFG_HREG_STATUS 4'h2
`define UCFG_HREG_IRQ_STAT 4'h3
`define UCFG_HREG_IRQ_MASK 4'h4
`define UCFG_CMD_GO_BIT 0
`define UCFG_CMD_WRITE_BIT 1
`endif

// *** logic/ucfg_pkg.sv ***
package ucfg_pkg;
  typedef logic [7:0] ucfg_byte_t;
  typedef enum logic [1:0] {
    UCFG_IDLE = 2'b00,
    UCFG_INDEX = 2'b01,
    UCFG_DATA = 2'b10,
    UCFG_WAIT = 2'b11
  } ucfg_host_state_t;
endpackage : ucfg_pkg

// *** logic/ucfg_link_if.sv ***
`timescale 1ns/100ps
interface ucfg_link_if;
  // configuration state and register strobes
  logic cfgMode;
  logic idxWr;
  logic dataWr;
  logic dataRd;
  logic [7:0] wrData;
  logic [7:0] rdData;
  logic rdValid;
  modport device (
    input cfgMode, idxWr, dataWr, dataRd, wrData,
    output rdData, rdValid
  );
  modport host (
    output cfgMode, idxWr, dataWr, dataRd, wrData,
    input rdData, rdValid
  );
endinterface : ucfg_link_if

// *** logic/ucfg_device.sv ***
`timescale 1ns/100ps
`include "ucfg_params.svh"
module ucfg_device (
  // clock and resets
  input wire logic clk,
  input wire logic rst_n,
  input wire logic standbyRst_n,
  // host link
  ucfg_link_if.device link,
  // serial port interrupt conditions and gates
  input wire logic [3:0] portIrq,
  input wire logic [3:0] portIrqGate,
  // host i/o address to decode
  input wire logic [15:0] ioAddr,
  // routed interrupt lines 0..15
  output logic [15:0] irqLineOut,
  output logic [15:0] irqLineOe,
  // decoder and configuration outputs
  output logic [1:0] portSelect,
  output logic slowClockAbsent
);
  ucfg_pkg::ucfg_byte_t indexReg_r;
  ucfg_pkg::ucfg_byte_t route_r;
  ucfg_pkg::ucfg_byte_t clock_r;
  ucfg_pkg::ucfg_byte_t base_r [2];
  ucfg_pkg::ucfg_byte_t rdData_r;
  logic rdValid_r;
  wire [15:0] lineOut_nxt;
  wire [15:0] lineOe_nxt;
  wire [1:0] portSelect_nxt;
  logic wrOk;

  assign wrOk = link.cfgMode && link.dataWr;

  // ----------------------------------------
  // index register
  // ----------------------------------------
  // index writes outside the configuration state are dropped
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      indexReg_r <= 8'h00;
    end else if (link.cfgMode && link.idxWr) begin
      indexReg_r <= link.wrData;
    end
  end

  // ----------------------------------------
  // main-supply registers
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      route_r <= `UCFG_RST_IRQ_ROUTE;
    end else if (wrOk && indexReg_r == `UCFG_IDX_IRQ_ROUTE) begin
      route_r <= link.wrData;
    end
  end

  // bit0 is not stored so it always reads zero
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      base_r[0] <= `UCFG_RST_BASE;
    end else if (wrOk && indexReg_r == `UCFG_IDX_BASE1) begin
      base_r[0] <= {link.wrData[7:1], 1'b0};
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      base_r[1] <= `UCFG_RST_BASE;
    end else if (wrOk && indexReg_r == `UCFG_IDX_BASE2) begin
      base_r[1] <= {link.wrData[7:1], 1'b0};
    end
  end

  // ----------------------------------------
  // standby-supply clock register
  // ----------------------------------------
  // only bit0 is writable; bit1 held at its default so a stray host write cannot move it
  always_ff @(posedge clk) begin
    if (!standbyRst_n) begin
      clock_r <= `UCFG_RST_CLOCK;
    end else if (wrOk && indexReg_r == `UCFG_IDX_CLOCK) begin
      clock_r <= {7'h00, link.wrData[`UCFG_CLK_ABSENT_BIT]};
    end
  end

  // ----------------------------------------
  // read path
  // ----------------------------------------
  // the answer pulse follows an accepted read strobe by one clock
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdValid_r <= 1'b0;
    end else begin
      rdValid_r <= link.cfgMode && link.dataRd;
    end
  end

  // read data follow the index every clock, so they stand with the answer
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdData_r <= 8'h00;
    end else begin
      unique case (indexReg_r)
        `UCFG_IDX_IRQ_ROUTE: rdData_r <= route_r;
        `UCFG_IDX_CLOCK: rdData_r <= clock_r;
        `UCFG_IDX_BASE1: rdData_r <= base_r[0];
        `UCFG_IDX_BASE2: rdData_r <= base_r[1];
        `UCFG_IDX_RSVD_B: rdData_r <= `UCFG_RST_RSVD_B;
        `UCFG_IDX_RSVD_F: rdData_r <= `UCFG_RST_RSVD_F;
        default: rdData_r <= `UCFG_RST_RSVD_A;
      endcase
    end
  end
  assign link.rdData = rdData_r;
  assign link.rdValid = rdValid_r;

  // ----------------------------------------
  // interrupt routing
  // ----------------------------------------
  // ports 1,2 route elsewhere; only ports 3,4 (index 2,3) use this register
  logic [3:0] sel3;
  logic [3:0] sel4;
  logic on3;
  logic on4;
  assign sel3 = route_r[`UCFG_ROUTE3_HI:`UCFG_ROUTE3_LO];
  assign sel4 = route_r[`UCFG_ROUTE4_HI:`UCFG_ROUTE4_LO];
  // a closed gate leaves the line undriven whatever the port's condition
  assign on3 = sel3 != 4'h0 && portIrqGate[2];
  assign on4 = sel4 != 4'h0 && portIrqGate[3];
  // port 3 wins a clash so a line never has two drivers
  for (genvar n = 0; n < 16; n++) begin : g_line
    logic hit3;
    logic hit4;
    assign hit3 = on3 && sel3 == 4'(n);
    assign hit4 = on4 && sel4 == 4'(n) && !hit3;
    assign lineOe_nxt[n] = hit3 || hit4;
    assign lineOut_nxt[n] = (hit3 && portIrq[2]) || (hit4 && portIrq[3]);
  end

  // ----------------------------------------
  // port address decode
  // ----------------------------------------
  // the select is registered, so it follows ioAddr by one clock
  // ioAddr bits 2:0 never take part in the match
  for (genvar p = 0; p < 2; p++) begin : g_decode
    logic topZero;
    logic baseHit;
    logic portOn;
    assign topZero = ioAddr[15:10] == 6'h00;
    assign baseHit = ioAddr[9:3] == base_r[p][7:1];
    assign portOn = base_r[p][7:6] != 2'h0;
    assign portSelect_nxt[p] = topZero && baseHit && portOn;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      portSelect <= 2'h0;
    end else begin
      portSelect <= portSelect_nxt;
    end
  end

  // ----------------------------------------
  // routed interrupt lines
  // ----------------------------------------
  // registered so the pins never glitch while the route register changes
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irqLineOut <= 16'h0000;
      irqLineOe <= 16'h0000;
    end else begin
      irqLineOut <= lineOut_nxt;
      irqLineOe <= lineOe_nxt;
    end
  end

  // ----------------------------------------
  // slow clock flag
  // ----------------------------------------
  // follows the standby register; the main reset only blanks it briefly
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      slowClockAbsent <= 1'b0;
    end else begin
      slowClockAbsent <= clock_r[`UCFG_CLK_ABSENT_BIT];
    end
  end
endmodule : ucfg_device

// *** logic/ucfg_host.sv ***
// Added by the designer: the strobed register port.
`timescale 1ns/100ps
`include "ucfg_params.svh"
module ucfg_host (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // software port
  input wire logic [3:0] swAddr,
  input wire logic [7:0] swWrData,
  input wire logic swWr,
  input wire logic swRd,
  output logic [7:0] swRdData,
  output logic irq,
  // device link
  ucfg_link_if.host link
);
  ucfg_pkg::ucfg_host_state_t state_r;
  ucfg_pkg::ucfg_byte_t index_r;
  ucfg_pkg::ucfg_byte_t data_r;
  logic write_r;
  logic busy_r;
  logic [1:0] irqStat_r;
  logic [1:0] irqMask_r;
  logic cfgMode_r;
  logic idxWr_r;
  logic dataWr_r;
  logic dataRd_r;
  ucfg_pkg::ucfg_byte_t wrData_r;
  logic doneEv;
  logic startEv;

  assign startEv = swWr && swAddr == `UCFG_HREG_CMD && swWrData[`UCFG_CMD_GO_BIT] && !busy_r;
  assign doneEv = (state_r == ucfg_pkg::UCFG_DATA && write_r) ||
    (state_r == ucfg_pkg::UCFG_WAIT && link.rdValid);

  // ----------------------------------------
  // sequencer: index write, then data access
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_r <= ucfg_pkg::UCFG_IDLE;
      busy_r <= 1'b0;
      cfgMode_r <= 1'b0;
      idxWr_r <= 1'b0;
      dataWr_r <= 1'b0;
      dataRd_r <= 1'b0;
      wrData_r <= 8'h00;
    end else begin
      idxWr_r <= 1'b0;
      dataWr_r <= 1'b0;
      dataRd_r <= 1'b0;
      unique case (state_r)
        ucfg_pkg::UCFG_IDLE: begin
          cfgMode_r <= 1'b0;
          if (startEv) begin
            state_r <= ucfg_pkg::UCFG_INDEX;
            busy_r <= 1'b1;
            cfgMode_r <= 1'b1;
            idxWr_r <= 1'b1;
            wrData_r <= swWrData;
          end
        end
        ucfg_pkg::UCFG_INDEX: begin
          state_r <= ucfg_pkg::UCFG_DATA;
          dataWr_r <= write_r;
          dataRd_r <= !write_r;
          wrData_r <= data_r;
        end
        ucfg_pkg::UCFG_DATA: begin
          state_r <= write_r ? ucfg_pkg::UCFG_IDLE : ucfg_pkg::UCFG_WAIT;
          busy_r <= !write_r;
        end
        ucfg_pkg::UCFG_WAIT: begin
          if (link.rdValid) begin
            state_r <= ucfg_pkg::UCFG_IDLE;
            busy_r <= 1'b0;
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // software registers
  // ----------------------------------------
  // base writes force bit0 low; clock writes keep bit1 low
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      index_r <= 8'h00;
      data_r <= 8'h00;
      write_r <= 1'b0;
      irqMask_r <= 2'h0;
    end else if (swWr && !busy_r) begin
      if (swAddr == `UCFG_HREG_CMD) begin
        index_r <= swWrData;
      end
      if (swAddr == `UCFG_HREG_DATA) begin
        if (index_r == `UCFG_IDX_BASE1 || index_r == `UCFG_IDX_BASE2) begin
          data_r <= {swWrData[7:1], 1'b0};
        end else if (index_r == `UCFG_IDX_CLOCK) begin
          data_r <= swWrData & 8'hFD;
        end else begin
          data_r <= swWrData;
        end
      end
      if (swAddr == `UCFG_HREG_STATUS) begin
        write_r <= swWrData[`UCFG_CMD_WRITE_BIT];
      end
      if (swAddr == `UCFG_HREG_IRQ_MASK) begin
        irqMask_r <= swWrData[1:0];
      end
    end else if (state_r == ucfg_pkg::UCFG_WAIT && link.rdValid) begin
      data_r <= link.rdData;
    end
  end

  // ----------------------------------------
  // interrupt status: bit0 write done, bit1 read done
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irqStat_r <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (doneEv && (write_r == (i == 0))) begin
          irqStat_r[i] <= 1'b1;
        end else if (swWr && swAddr == `UCFG_HREG_IRQ_STAT && swWrData[i]) begin
          irqStat_r[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      swRdData <= 8'h00;
      irq <= 1'b0;
    end else begin
      // a set mask bit hides its status bit from the interrupt line
      irq <= |(irqStat_r & ~irqMask_r);
      if (swRd) begin
        unique case (swAddr)
          `UCFG_HREG_CMD: swRdData <= index_r;
          `UCFG_HREG_DATA: swRdData <= data_r;
          `UCFG_HREG_STATUS: swRdData <= {6'h00, write_r, busy_r};
          `UCFG_HREG_IRQ_STAT: swRdData <= {6'h00, irqStat_r};
          `UCFG_HREG_IRQ_MASK: swRdData <= {6'h00, irqMask_r};
          default: swRdData <= 8'h00;
        endcase
      end
    end
  end

  assign link.cfgMode = cfgMode_r;
  assign link.idxWr = idxWr_r;
  assign link.dataWr = dataWr_r;
  assign link.dataRd = dataRd_r;
  assign link.wrData = wrData_r;
endmodule : ucfg_host

// *** tb/ucfg_link_props.sv ***
`timescale 1ns/100ps
// ----------------------------------------
// link checker
// ----------------------------------------
module ucfg_link_props (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // link signals
  input wire logic cfgMode,
  input wire logic idxWr,
  input wire logic dataWr,
  input wire logic dataRd,
  input wire logic [7:0] wrData,
  input wire logic [7:0] rdData,
  input wire logic rdValid
);
  logic [7:0] idx_r;
  logic [7:0] route_r;
  logic [7:0] base2_r;
  // shadow copies, reset with the main reset like the device's index, route and base registers
  always_ff @(posedge clk) begin
    if (!rst_n) idx_r <= 8'h00;
    else if (cfgMode && idxWr) idx_r <= wrData;
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      route_r <= 8'h00;
      base2_r <= 8'h00;
    end else if (cfgMode && dataWr && idx_r == 8'h1D) route_r <= wrData;
    else if (cfgMode && dataWr && idx_r == 8'h25) base2_r <= {wrData[7:1], 1'b0};
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_rd_answer: assert property (cfgMode && dataRd |=> rdValid)
    else $error("read not answered");
  chk_stray_valid: assert property (rdValid |-> $past(dataRd) && $past(cfgMode))
    else $error("answer without read");
  chk_mode_held: assert property (dataWr || dataRd |-> cfgMode)
    else $error("strobe outside config state");
  chk_index_first: assert property ($rose(cfgMode) |-> idxWr)
    else $error("config state opened without index");
  chk_strobe_apart: assert property (!(dataWr && dataRd))
    else $error("read and write together");
  chk_route_back: assert property (rdValid && idx_r == 8'h1D |-> rdData == route_r)
    else $error("route register readback");
  chk_base_back: assert property (rdValid && idx_r == 8'h25 |-> rdData == base2_r)
    else $error("base register readback");
  chk_rsvd_fixed: assert property (rdValid && idx_r inside {8'h1F, 8'h21, 8'h23, 8'h27}
    |-> rdData == 8'h00)
    else $error("reserved register changed");
endmodule : ucfg_link_props

// *** tb/uart_irq_and_base_addr_config_test.sv ***
`timescale 1ns/100ps
module uart_irq_and_base_addr_config_test;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic sbyRst_n = 1'b0;
  logic [3:0] swAddr = 4'h0;
  logic [7:0] swWrData = 8'h00;
  logic swWr = 1'b0;
  logic swRd = 1'b0;
  logic [3:0] portIrq = 4'h0;
  logic [3:0] portIrqGate = 4'h0;
  logic [15:0] ioAddr = 16'h0000;
  logic [7:0] swRdData, rd;
  logic irq, abs0, abs1;
  logic masked = 1'b0;
  logic [15:0] out0, oe0, out1, oe1;
  logic [1:0] sel0, sel1;
  int failures = 0;
  int total_checks = 0;
  // base, i/o address, decode hit
  logic [24:0] bt [6] = '{{8'hFF, 16'h03F8, 1'b1}, {8'hFF, 16'h03FF, 1'b1},
    {8'hFF, 16'h03F7, 1'b0}, {8'hFF, 16'h43F8, 1'b0}, {8'h41, 16'h0107, 1'b1},
    {8'h3F, 16'h00F8, 1'b0}};
  ucfg_link_if link0 ();
  ucfg_link_if link1 ();
  always #25 clk = ~clk;
  ucfg_host ucfg_host_i (.clk(clk), .rst_n(rst_n), .swAddr(swAddr), .swWrData(swWrData),
    .swWr(swWr), .swRd(swRd), .swRdData(swRdData), .irq(irq), .link(link0));
  ucfg_device ucfg_device_i (.clk(clk), .rst_n(rst_n), .standbyRst_n(sbyRst_n), .link(link0),
    .portIrq(portIrq), .portIrqGate(portIrqGate), .ioAddr(ioAddr), .irqLineOut(out0),
    .irqLineOe(oe0), .portSelect(sel0), .slowClockAbsent(abs0));
  // second device driven straight by the bench: reaches even indices and refusals
  ucfg_device ucfg_device_i2 (.clk(clk), .rst_n(rst_n), .standbyRst_n(sbyRst_n), .link(link1),
    .portIrq(portIrq), .portIrqGate(portIrqGate), .ioAddr(ioAddr), .irqLineOut(out1),
    .irqLineOe(oe1), .portSelect(sel1), .slowClockAbsent(abs1));
  ucfg_link_props ucfg_link_props_i (.clk(clk), .rst_n(rst_n), .cfgMode(link0.cfgMode),
    .idxWr(link0.idxWr), .dataWr(link0.dataWr), .dataRd(link0.dataRd),
    .wrData(link0.wrData), .rdData(link0.rdData), .rdValid(link0.rdValid));
  // ----------------------------------------
  // access tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic sw_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    swAddr <= a;
    swWrData <= d;
    swWr <= 1'b1;
    @(posedge clk);
    swWr <= 1'b0;
  endtask : sw_wr
  task automatic sw_rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    swAddr <= a;
    swRd <= 1'b1;
    @(posedge clk);
    swRd <= 1'b0;
    #1;
    d = swRdData;
  endtask : sw_rd
  // only odd indices start from the host, a limitation of its start bit
  task automatic hcfg(input logic [7:0] i, input logic wr, input logic [7:0] d,
      output logic [7:0] q);
    logic [7:0] s;
    sw_wr(4'h2, {6'h00, wr, 1'b0});
    sw_wr(4'h1, d);
    sw_wr(4'h0, i);
    s = 8'h01;
    for (int n = 0; n < 20 && s[0] !== 1'b0; n++) sw_rd(4'h2, s);
    sw_rd(4'h3, s);
    chk("done flag", wr ? 8'h01 : 8'h02, s);
    chk("irq", !masked, irq);
    sw_wr(4'h3, 8'h03);
    repeat (2) @(posedge clk);
    chk("irq cleared", 1'b0, irq);
    sw_rd(4'h1, q);
  endtask : hcfg
  task automatic lk(input logic m, input logic [7:0] i, input logic wr, input logic [7:0] d,
      output logic [7:0] q);
    @(posedge clk);
    link1.cfgMode <= m;
    link1.idxWr <= 1'b1;
    link1.wrData <= i;
    @(posedge clk);
    link1.idxWr <= 1'b0;
    link1.dataWr <= wr;
    link1.dataRd <= !wr;
    link1.wrData <= d;
    @(posedge clk);
    link1.dataWr <= 1'b0;
    link1.dataRd <= 1'b0;
    link1.cfgMode <= 1'b0;
    link1.wrData <= ~d;
    #1;
    q = link1.rdData;
    if (!wr) chk("answer", m, link1.rdValid);
  endtask : lk
  task automatic results();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : results
  initial begin
    #500000;
    failures++;
    $display("watchdog expired");
    results();
  end
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    {link1.cfgMode, link1.idxWr, link1.dataWr, link1.dataRd} = 4'h0;
    link1.wrData = 8'h00;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    sbyRst_n <= 1'b1;
    for (int i = 8'h1D; i <= 8'h27; i++) begin
      rd = (i == 8'h20) ? 8'h3C : (i == 8'h26) ? 8'hFF : 8'h00;
      if (i inside {8'h1F, [8'h20:8'h23], 8'h26, 8'h27}) lk(1'b1, i, 1'b1, ~rd, rd);
      lk(1'b1, i, 1'b0, 8'h00, rd);
      chk("reset value", (i == 8'h20) ? 8'h3C : (i == 8'h26) ? 8'hFF : 8'h00, rd);
    end
    lk(1'b0, 8'h1D, 1'b1, 8'h77, rd);
    lk(1'b1, 8'h1D, 1'b0, 8'h00, rd);
    chk("refused write", 8'h00, rd);
    $display("test reset and reserved done");
    portIrqGate <= 4'hC;
    portIrq <= 4'h4;
    hcfg(8'h1D, 1'b1, 8'h5A, rd);
    hcfg(8'h1D, 1'b0, 8'h00, rd);
    chk("route", 8'h5A, rd);
    chk("line enable", 16'h0420, oe0);
    chk("line level", 16'h0020, out0 & oe0);
    portIrqGate <= 4'h4;
    repeat (2) @(posedge clk);
    chk("gated line", 16'h0020, oe0);
    portIrqGate <= 4'hC;
    sw_wr(4'h4, 8'h03);
    masked = 1'b1;
    hcfg(8'h1D, 1'b1, 8'h55, rd);
    sw_wr(4'h4, 8'h00);
    masked = 1'b0;
    chk("one driver", 16'h0020, oe0);
    hcfg(8'h1D, 1'b1, 8'h00, rd);
    chk("unrouted", 16'h0000, oe0);
    $display("test routing done");
    foreach (bt[k]) begin
      lk(1'b1, 8'h24, 1'b1, bt[k][24:17], rd);
      lk(1'b1, 8'h25, 1'b1, bt[k][24:17], rd);
      hcfg(8'h25, 1'b1, bt[k][24:17], rd);
      ioAddr <= bt[k][16:1];
      repeat (2) @(posedge clk);
      chk("decode", {2{bt[k][0]}}, sel1);
      chk("host decode", bt[k][0], sel0[1]);
      lk(1'b1, 8'h24, 1'b0, 8'h00, rd);
      chk("base readback", {bt[k][24:18], 1'b0}, rd);
    end
    for (int i = 8'h1F; i <= 8'h27; i += 2) begin
      hcfg(i, 1'b0, 8'h00, rd);
      chk("host readback", (i == 8'h25) ? 8'h3E : 8'h00, rd);
    end
    $display("test base decode done");
    lk(1'b1, 8'h1E, 1'b1, 8'h01, rd);
    lk(1'b1, 8'h1E, 1'b0, 8'h00, rd);
    chk("clock reg", 8'h01, rd);
    chk("slow clock absent", 1'b1, abs1);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    lk(1'b1, 8'h1E, 1'b0, 8'h00, rd);
    chk("clock after main reset", 8'h01, rd);
    lk(1'b1, 8'h24, 1'b0, 8'h00, rd);
    chk("base after main reset", 8'h00, rd);
    sbyRst_n <= 1'b0;
    repeat (2) @(posedge clk);
    sbyRst_n <= 1'b1;
    lk(1'b1, 8'h1E, 1'b0, 8'h00, rd);
    chk("clock after standby reset", 8'h00, rd);
    chk("slow clock present", 1'b0, abs1);
    $display("test clock register done");
    results();
  end
endmodule : uart_irq_and_base_addr_config_test
